// [hw/master_spi_mode_core.sv]
/*
  master-only spi mode of a serial port: apb registers, double buffered
  transmitter, two-level receive buffer, clock divider and shifter.
  assumes sys_clk at 125 MHz, an apb master, and a cpu that supplies the
  global interrupt enable and acknowledges the transmit complete interrupt.
*/
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (RULE_01) frame error, overrun and parity flags unused, always read zero.
// (RULE_02) receive complete flag high while receive buffer holds unread data.
// (RULE_03) transmit complete sets when shifter empties and no byte waits.
// (RULE_04) transmit complete clears on interrupt taken or written one.
// (RULE_05) buffer empty flag high when transmit buffer free; set after reset.
// (RULE_06) software writes zero to reserved low five bits of status a.
// (RULE_07) receive interrupt needs its enable, global enable and flag.
// (RULE_08) transmit complete interrupt needs its enable, global enable and flag.
// (RULE_09) buffer empty interrupt needs its enable, global enable and flag.
// (RULE_10) receiver enable owns input pin; disabling flushes receive buffer.
// (RULE_11) software enables transmitter for reception; it makes the clock.
// (RULE_12) transmitter drives output pin; disable waits until all data sent.
// (RULE_13) software writes zero to reserved low three bits of control b.
// (RULE_14) two-bit mode field: async, sync, reserved, master spi.
// (RULE_15) order, phase, polarity taken in same write selecting spi mode.
// (RULE_16) middle three bits of control c read zero, written zero.
// (RULE_17) order bit set shifts least significant bit first, else most.
// (RULE_18) phase bit chooses sampling on leading or trailing clock edge.
// (RULE_19) polarity bit sets serial clock idle level, with phase sets timing.
// (RULE_20) transmitter double buffered; receiver has one extra buffer level.
// (RULE_21) master only: no slave select, collision flag or double speed.
// (RULE_22) data shifted out and sampled on opposite clock edges.
// (RULE_23) a data register write starts a transfer when shifter frees.
// (RULE_24) frames are eight bits; back to back or line idles high.
// (RULE_25) on receive overflow the newest byte is dropped.
// (RULE_26) serial clock divided from system clock; rests at polarity level.
module master_spi_mode_core
  import master_spi_mode_pkg::*;
#(
  parameter int BAUD_W = MASTER_SPI_MODE_BAUD_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic global_irq_en,
  input wire logic tx_irq_taken,
  output logic rx_irq_req,
  output logic tx_irq_req,
  output logic empty_irq_req,
  // serial pins
  output logic serial_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic serial_in_pin,
  output logic serial_in_owned
);
  // reset release through two flops
  logic rst_a_r, rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  // register state
  logic [7:0] ctrl_b_r, ctrl_c_r;
  logic [BAUD_W-1:0] baud_r;
  logic txc_r, txen_eff_r;
  logic [7:0] txbuf_r;
  logic txbuf_full_r;
  logic [7:0] rxbuf_r [2];
  logic [1:0] rx_cnt_r;
  logic [31:0] prdata_r;

  // bus decode
  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire hit_a = paddr == MASTER_SPI_MODE_OFF_CSR_A;
  wire hit_b = paddr == MASTER_SPI_MODE_OFF_CSR_B;
  wire hit_c = paddr == MASTER_SPI_MODE_OFF_CSR_C;
  wire hit_d = paddr == MASTER_SPI_MODE_OFF_DATA;
  wire hit_u = paddr == MASTER_SPI_MODE_OFF_BAUD;
  wire mapped = hit_a | hit_b | hit_c | hit_d | hit_u;
  wire wr_a = wr_acc & hit_a;
  wire wr_b = wr_acc & hit_b;
  wire wr_c = wr_acc & hit_c;
  wire wr_d = wr_acc & hit_d;
  wire wr_u = wr_acc & hit_u;
  wire rd_d = rd_acc & hit_d;

  // control fields
  wire rxcie = ctrl_b_r[MASTER_SPI_MODE_B_RXCIE];
  wire txcie = ctrl_b_r[MASTER_SPI_MODE_B_TXCIE];
  wire tx_empty_irq_en = ctrl_b_r[MASTER_SPI_MODE_B_TX_EMPTY_IRQ_EN];
  wire rxen = ctrl_b_r[MASTER_SPI_MODE_B_RXEN];
  // (RULE_14) mode field decode
  wire [1:0] mode = ctrl_c_r[MASTER_SPI_MODE_C_MODE_HI:MASTER_SPI_MODE_C_MODE_LO];
  wire spi_mode = mode == MASTER_SPI_MODE_MODE_SPI;
  wire lsb_first = ctrl_c_r[MASTER_SPI_MODE_C_ORDER];
  wire cpha = ctrl_c_r[MASTER_SPI_MODE_C_CPHA];
  wire cpol = ctrl_c_r[MASTER_SPI_MODE_C_CPOL];

  // flags
  // (RULE_02) flag follows buffer fill
  wire rxc = rx_cnt_r != 2'h0;
  // (RULE_05) empty whenever buffer free
  wire udre = ~txbuf_full_r;

  // (RULE_01) error bits and reserved bits read zero
  wire [7:0] csr_a = {rxc, txc_r, udre, 5'h00};
  // (RULE_16) middle bits of c read zero
  wire [7:0] csr_c = ctrl_c_r & MASTER_SPI_MODE_C_WMASK;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_a) rd_mux = {24'h00_0000, csr_a};
    if (hit_b) rd_mux = {24'h00_0000, ctrl_b_r};
    if (hit_c) rd_mux = {24'h00_0000, csr_c};
    if (hit_d) rd_mux = {24'h00_0000, rxbuf_r[0]};
    if (hit_u) rd_mux = {{(32 - BAUD_W){1'b0}}, baud_r};
  end

  // read data captured in setup, answered in access with no wait
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prdata_r <= 32'h0000_0000;
    else if (setup_ph) prdata_r <= rd_mux;
  end
  assign prdata = prdata_r;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // (RULE_15) one write takes mode, order, phase, polarity together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_r <= 8'h00;
      ctrl_c_r <= MASTER_SPI_MODE_C_RESET;
      baud_r <= '0;
    end else begin
      if (wr_b) ctrl_b_r <= pwdata[7:0] & MASTER_SPI_MODE_B_WMASK;
      if (wr_c) ctrl_c_r <= pwdata[7:0] & MASTER_SPI_MODE_C_WMASK;
      if (wr_u) baud_r <= pwdata[BAUD_W-1:0];
    end
  end

  // input synchroniser, change accepted when stages two and three agree
  logic sin1_r, sin2_r, sin3_r, din_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sin1_r <= 1'b1;
      sin2_r <= 1'b1;
      sin3_r <= 1'b1;
      din_r <= 1'b1;
    end else begin
      sin1_r <= serial_in_pin;
      sin2_r <= sin1_r;
      sin3_r <= sin2_r;
      if (sin2_r == sin3_r) din_r <= sin3_r;
    end
  end

  // shifter state
  master_spi_mode_state_e state_r;
  logic [BAUD_W-1:0] div_r;
  logic [3:0] edge_r;
  logic sck_r;
  logic [7:0] tx_sh_r, rx_sh_r;

  wire busy = state_r == MASTER_SPI_MODE_SHIFT;
  // (RULE_26) half period is baud plus one system clocks
  wire half_tick = busy & (div_r == baud_r);
  wire last_edge = half_tick & (edge_r == MASTER_SPI_MODE_LAST_EDGE);
  // (RULE_22) sample on one edge kind, shift on the other
  // (RULE_18) phase picks leading or trailing sample edge
  wire sample_ev = half_tick & (edge_r[0] == cpha);
  wire shift_ev = half_tick & (edge_r[0] != cpha) & (edge_r != 4'h0) & ~last_edge;
  // (RULE_11) only the transmitter starts frames, and it makes the clock
  // (RULE_23) buffered byte moves to shifter when it frees
  wire can_load = spi_mode & txen_eff_r & txbuf_full_r;
  wire load_idle = ~busy & can_load;
  wire load_next = last_edge & can_load;
  wire load = load_idle | load_next;
  wire frame_end = last_edge;
  wire [7:0] rx_next = lsb_first ? {din_r, rx_sh_r[7:1]} : {rx_sh_r[6:0], din_r};
  // phase 0 takes its eighth bit a half period before the last edge
  wire [7:0] rx_byte = cpha ? rx_next : rx_sh_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MASTER_SPI_MODE_IDLE;
      div_r <= '0;
      edge_r <= 4'h0;
      sck_r <= 1'b0;
      tx_sh_r <= 8'hff;
      rx_sh_r <= 8'h00;
    end else begin
      unique case (state_r)
        MASTER_SPI_MODE_IDLE: begin
          // (RULE_26) clock rests at polarity level
          sck_r <= cpol;
          div_r <= '0;
          edge_r <= 4'h0;
          // line idles high one clock after the last edge, keeping hold time
          if (load_idle) begin
            tx_sh_r <= txbuf_r;
            state_r <= MASTER_SPI_MODE_SHIFT;
          end else tx_sh_r <= 8'hff;
        end
        MASTER_SPI_MODE_SHIFT: begin
          div_r <= half_tick ? '0 : div_r + 1'b1;
          if (half_tick) begin
            sck_r <= ~sck_r;
            edge_r <= edge_r + 4'h1;
          end
          if (sample_ev) rx_sh_r <= rx_next;
          // (RULE_17) order bit picks shift direction
          if (shift_ev) tx_sh_r <= lsb_first ? {1'b1, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b1};
          // (RULE_24) eight bits per frame, next frame may follow at once
          if (load_next) tx_sh_r <= txbuf_r;
          else if (last_edge) state_r <= MASTER_SPI_MODE_IDLE;
        end
      endcase
    end
  end

  // (RULE_20) transmit buffer beside the shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_r <= 8'h00;
      txbuf_full_r <= 1'b0;
    end else begin
      if (wr_d) begin
        txbuf_r <= pwdata[7:0];
        txbuf_full_r <= 1'b1;
      end else if (load) txbuf_full_r <= 1'b0;
    end
  end

  // (RULE_03) set on empty shifter with no waiting byte
  // (RULE_04) clear on interrupt taken or written one, set wins
  wire txc_set = frame_end & ~load_next;
  wire txc_clr = tx_irq_taken | (wr_a & pwdata[MASTER_SPI_MODE_A_TXC]);
  // (RULE_12) disable takes hold only once all data has gone
  wire tx_drained = ~busy & ~txbuf_full_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_r <= 1'b0;
      txen_eff_r <= 1'b0;
    end else begin
      if (txc_set) txc_r <= 1'b1;
      else if (txc_clr) txc_r <= 1'b0;
      if (ctrl_b_r[MASTER_SPI_MODE_B_TXEN]) txen_eff_r <= 1'b1;
      else if (tx_drained) txen_eff_r <= 1'b0;
    end
  end

  // receive buffer, entry 0 is the oldest
  wire rx_push = frame_end & rxen;
  wire rx_pop = rd_d & rxc;
  logic [1:0] rx_cnt_nxt;
  always_comb begin
    rx_cnt_nxt = rx_cnt_r;
    if (rx_pop) rx_cnt_nxt = rx_cnt_nxt - 2'h1;
    // (RULE_25) full buffer drops the newest byte
    if (rx_push && rx_cnt_nxt != MASTER_SPI_MODE_RX_DEPTH) rx_cnt_nxt = rx_cnt_nxt + 2'h1;
    // (RULE_10) disable flushes unread data
    if (!rxen) rx_cnt_nxt = 2'h0;
  end
  wire [1:0] push_slot = rx_pop ? rx_cnt_r - 2'h1 : rx_cnt_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= 2'h0;
      rxbuf_r[0] <= 8'h00;
      rxbuf_r[1] <= 8'h00;
    end else begin
      rx_cnt_r <= rx_cnt_nxt;
      if (rx_pop) rxbuf_r[0] <= rxbuf_r[1];
      if (rx_push && push_slot != MASTER_SPI_MODE_RX_DEPTH) rxbuf_r[push_slot[0]] <= rx_byte;
    end
  end

  // (RULE_07) receive interrupt gating
  assign rx_irq_req = rxcie & global_irq_en & rxc;
  // (RULE_08) transmit complete gating
  assign tx_irq_req = txcie & global_irq_en & txc_r;
  // (RULE_09) buffer empty gating
  assign empty_irq_req = tx_empty_irq_en & global_irq_en & udre;

  // (RULE_12) pin driven while transmitter active, idles high
  // (RULE_21) no slave select pin: master only
  assign serial_out_pin = lsb_first ? tx_sh_r[0] : tx_sh_r[7];
  assign serial_out_oe_n = ~txen_eff_r;
  assign serial_clock_pin = sck_r;
  // (RULE_10) receiver owns the input pin
  assign serial_in_owned = rxen;

  // checks
  sequence s_clock_rest;
    !busy ##1 !busy && $stable(cpol);
  endsequence
  property p_err_bits_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      setup_ph && hit_a |=> prdata[4:0] == 5'h00;
  endproperty
  a_err_bits_zero: assert property (p_err_bits_zero) else $error("error bits not zero"); // RULE_01
  property p_rx_flush;
    @(posedge sys_clk) disable iff (!rst_n)
      !rxen |=> !rxc;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("flag set after flush"); // RULE_10
  property p_txc_set;
    @(posedge sys_clk) disable iff (!rst_n)
      frame_end && !can_load |=> txc_r ##1 (txc_r || $past(txc_clr));
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("tx complete missed"); // RULE_03
  property p_txc_clr;
    @(posedge sys_clk) disable iff (!rst_n)
      tx_irq_taken && !frame_end |=> !txc_r;
  endproperty
  a_txc_clr: assert property (p_txc_clr) else $error("tx complete not cleared"); // RULE_04
  property p_udre_reset;
    @(posedge sys_clk) $rose(rst_n) |-> udre;
  endproperty
  a_udre_reset: assert property (p_udre_reset) else $error("empty flag low at reset"); // RULE_05
  property p_rx_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      rx_irq_req |-> rxcie && global_irq_en && rx_cnt_r != 2'h0;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("bad rx request"); // RULE_07
  property p_tx_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(tx_irq_req) |-> $rose(txc_r) || $rose(txcie) || $rose(global_irq_en);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("bad tx request"); // RULE_08
  property p_empty_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_d && tx_empty_irq_en && global_irq_en |=> !empty_irq_req;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty request after write"); // RULE_09
  property p_clock_rest;
    @(posedge sys_clk) disable iff (!rst_n)
      s_clock_rest |-> serial_clock_pin == cpol;
  endproperty
  a_clock_rest: assert property (p_clock_rest) else $error("clock not at rest level"); // RULE_26
  property p_tx_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_b_r[MASTER_SPI_MODE_B_TXEN] && busy |=> !serial_out_oe_n;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("pin released mid frame"); // RULE_12
endmodule

`default_nettype wire

// [hw/master_spi_mode_pkg.sv]
/*
  register map, field positions, reset values and states of the
  master-only spi serial port.
  assumes a 32-bit apb bus with one aligned word per register.
*/
package master_spi_mode_pkg;
  // register byte addresses
  localparam logic [7:0] MASTER_SPI_MODE_OFF_CSR_A = 8'h00;
  localparam logic [7:0] MASTER_SPI_MODE_OFF_CSR_B = 8'h04;
  localparam logic [7:0] MASTER_SPI_MODE_OFF_CSR_C = 8'h08;
  localparam logic [7:0] MASTER_SPI_MODE_OFF_DATA = 8'h0c;
  localparam logic [7:0] MASTER_SPI_MODE_OFF_BAUD = 8'h10;
  // status a fields
  localparam int MASTER_SPI_MODE_A_RXC = 7;
  localparam int MASTER_SPI_MODE_A_TXC = 6;
  localparam int MASTER_SPI_MODE_A_UDRE = 5;
  // control b fields
  localparam int MASTER_SPI_MODE_B_RXCIE = 7;
  localparam int MASTER_SPI_MODE_B_TXCIE = 6;
  localparam int MASTER_SPI_MODE_B_TX_EMPTY_IRQ_EN = 5;
  localparam int MASTER_SPI_MODE_B_RXEN = 4;
  localparam int MASTER_SPI_MODE_B_TXEN = 3;
  // control c fields
  localparam int MASTER_SPI_MODE_C_MODE_HI = 7;
  localparam int MASTER_SPI_MODE_C_MODE_LO = 6;
  localparam int MASTER_SPI_MODE_C_ORDER = 2;
  localparam int MASTER_SPI_MODE_C_CPHA = 1;
  localparam int MASTER_SPI_MODE_C_CPOL = 0;
  localparam logic [7:0] MASTER_SPI_MODE_C_RESET = 8'h06;
  localparam logic [7:0] MASTER_SPI_MODE_C_WMASK = 8'hc7;
  localparam logic [7:0] MASTER_SPI_MODE_B_WMASK = 8'hf8;
  // operating modes
  localparam logic [1:0] MASTER_SPI_MODE_MODE_ASYNC = 2'h0;
  localparam logic [1:0] MASTER_SPI_MODE_MODE_SYNC = 2'h1;
  localparam logic [1:0] MASTER_SPI_MODE_MODE_RSVD = 2'h2;
  localparam logic [1:0] MASTER_SPI_MODE_MODE_SPI = 2'h3;
  // frame and buffer shape
  localparam int MASTER_SPI_MODE_BAUD_W = 12;
  localparam logic [3:0] MASTER_SPI_MODE_LAST_EDGE = 4'hf;
  localparam logic [1:0] MASTER_SPI_MODE_RX_DEPTH = 2'h2;
  typedef enum logic [0:0] {
    MASTER_SPI_MODE_IDLE = 1'b0,
    MASTER_SPI_MODE_SHIFT = 1'b1
  } master_spi_mode_state_e;
endpackage

// [verif/master_spi_mode_slave_model.sv]
/*
  behavioural spi slave facing the master-only serial port.
  assumes the bench gives it the clock mode and bit order, and that
  frames only run while en is high.
*/
`timescale 1ns/1ps
`default_nettype none
module master_spi_mode_slave_model (
  // serial lines
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // mode from the bench
  input wire logic en,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  // observation
  output logic [7:0] frames,
  output logic [7:0] last_rx
);
  logic [7:0] sh = 8'h00;
  logic [7:0] cur;
  logic miso_r = 1'b0;
  int ns = 0;
  int n = 0;
  initial frames = 8'h00;
  initial last_rx = 8'h00;
  // reply byte changes every frame so order errors show
  assign cur = 8'ha5 ^ frames;
  assign miso = cpha ? miso_r : cur[lsb ? n : 7 - n];
  always @(sck) begin
    if (en) begin
      if ((sck !== cpol) ^ cpha) begin
        sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        ns = ns + 1;
        if (ns == 8) begin
          ns = 0;
          last_rx = sh;
          // hold time over: no stale bit left on the line
          if (cpha) miso_r = ~miso_r;
        end
      end else begin
        if (cpha) miso_r = cur[lsb ? n : 7 - n];
        n = n + 1;
        if (n == 8) begin
          n = 0;
          frames = frames + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/master_spi_mode_core_tb.sv]
/*
  self-checking bench for the master-only spi serial port.
  assumes the design package and the spi slave model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module master_spi_mode_core_tb;
  import master_spi_mode_pkg::*;
  localparam logic [7:0] RA = MASTER_SPI_MODE_OFF_CSR_A;
  localparam logic [7:0] RB = MASTER_SPI_MODE_OFF_CSR_B;
  localparam logic [7:0] RC = MASTER_SPI_MODE_OFF_CSR_C;
  localparam logic [7:0] RD = MASTER_SPI_MODE_OFF_DATA;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic global_irq_en = 1'b0;
  logic tx_irq_taken = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_irq_req;
  logic tx_irq_req;
  logic empty_irq_req;
  logic serial_clock_pin;
  logic serial_out_pin;
  logic serial_out_oe_n;
  logic serial_in_pin;
  logic serial_in_owned;
  logic mosi;
  logic [7:0] frames;
  logic [7:0] last_rx;
  logic [7:0] creg = 8'h06;
  logic [31:0] rdat;
  logic rerr;
  logic [31:0] cyc = 32'h0;
  int err_count = 0;
  int cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 32'h1;
  // port logic keeps the line high once released
  assign mosi = serial_out_oe_n ? 1'b1 : serial_out_pin;
  master_spi_mode_core master_spi_mode_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
    .tx_irq_taken(tx_irq_taken), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
    .empty_irq_req(empty_irq_req), .serial_clock_pin(serial_clock_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
    .serial_in_pin(serial_in_pin), .serial_in_owned(serial_in_owned));
  master_spi_mode_slave_model master_spi_mode_slave_model_i (.sck(serial_clock_pin), .mosi(mosi),
    .miso(serial_in_pin), .en(!serial_out_oe_n), .cpol(creg[0]), .cpha(creg[1]),
    .lsb(creg[2]), .frames(frames), .last_rx(last_rx));
  task automatic wrap_up;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  task automatic wait_a(input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, RA, 32'h0);
      if (rdat[b] === 1'b1) break;
    end
    chk("flag wait", 32'(i < 400), 32'h1);
  endtask
  task automatic wrc(input logic [7:0] v);
    creg = v;
    apb(1'b1, RC, {24'h0, v});
  endtask
  task automatic t_reset;
    chk("oe_n", 32'(serial_out_oe_n), 32'h1);
    chk("sck", 32'(serial_clock_pin), 32'h0);
    rchk("status a", RA, 32'h20);
    rchk("control b", RB, 32'h0);
    rchk("control c", RC, 32'h06);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'(rerr), 32'h1);
    chk("unmapped", rdat, 32'h0);
  endtask
  task automatic t_modes;
    logic [7:0] k;
    apb(1'b1, MASTER_SPI_MODE_OFF_BAUD, 32'h4);
    wrc(8'h00);
    apb(1'b1, RB, 32'h18);
    k = frames;
    apb(1'b1, RD, 32'h3c);
    for (int m = 1; m < 3; m++) begin
      repeat (200) @(posedge sys_clk);
      wrc(8'(m) << 6);
    end
    repeat (200) @(posedge sys_clk);
    chk("no frame", 32'(frames), 32'(k));
    wrc(8'hc0);
    wait_a(MASTER_SPI_MODE_A_TXC);
    chk("mosi byte", 32'(last_rx), 32'h3c);
    rchk("miso byte", RD, 32'(8'ha5 ^ k));
  endtask
  task automatic t_fmt;
    logic [7:0] k;
    for (int f = 0; f < 8; f++) begin
      apb(1'b1, RB, 32'h0);
      wrc(8'hc0 | 8'(f));
      apb(1'b1, RB, 32'h18);
      apb(1'b1, RA, 32'h40);
      rchk("a cleared", RA, 32'h20);
      k = frames;
      apb(1'b1, RD, 32'(8'h96 + f));
      wait_a(MASTER_SPI_MODE_A_TXC);
      chk("mosi fmt", 32'(last_rx), 32'(8'h96 + f));
      rchk("a done", RA, 32'he0);
      rchk("miso fmt", RD, 32'(8'ha5 ^ k));
      chk("sck idle", 32'(serial_clock_pin), 32'(f & 1));
      chk("out idle", 32'(serial_out_pin), 32'h1);
    end
  endtask
  task automatic t_b2b;
    logic [7:0] k;
    logic [31:0] t;
    // clock rest level moves only while the slave is not listening
    apb(1'b1, RB, 32'h0);
    wrc(8'hc0);
    apb(1'b1, RB, 32'h18);
    apb(1'b1, RA, 32'h40);
    k = frames;
    apb(1'b1, RD, 32'h11);
    apb(1'b1, RD, 32'h22);
    rchk("buffer full", RA, 32'h0);
    @(serial_clock_pin);
    t = cyc;
    @(serial_clock_pin);
    chk("half period", cyc - t, 32'h5);
    wait_a(MASTER_SPI_MODE_A_UDRE);
    apb(1'b1, RD, 32'h33);
    wait_a(MASTER_SPI_MODE_A_TXC);
    chk("frames", 32'(frames - k), 32'h3);
    rchk("first", RD, 32'(8'ha5 ^ k));
    rchk("second", RD, 32'(8'ha5 ^ (k + 8'h1)));
    rchk("dropped", RA, 32'h60);
  endtask
  task automatic t_irq;
    apb(1'b1, RA, 32'h40);
    apb(1'b1, RB, 32'hf8);
    @(posedge sys_clk) global_irq_en <= 1'b1;
    @(negedge sys_clk);
    chk("empty irq", 32'(empty_irq_req), 32'h1);
    chk("tx irq off", 32'(tx_irq_req), 32'h0);
    apb(1'b1, RD, 32'h77);
    wait_a(MASTER_SPI_MODE_A_TXC);
    chk("rx irq", 32'(rx_irq_req), 32'h1);
    chk("tx irq", 32'(tx_irq_req), 32'h1);
    @(posedge sys_clk) global_irq_en <= 1'b0;
    @(negedge sys_clk);
    chk("gated", 32'({rx_irq_req, tx_irq_req, empty_irq_req}), 32'h0);
    @(posedge sys_clk) global_irq_en <= 1'b1;
    @(posedge sys_clk) tx_irq_taken <= 1'b1;
    @(posedge sys_clk) tx_irq_taken <= 1'b0;
    @(negedge sys_clk);
    chk("taken", 32'(tx_irq_req), 32'h0);
    rchk("a taken", RA, 32'ha0);
    apb(1'b0, RD, 32'h0);
    chk("rx irq pop", 32'(rx_irq_req), 32'h0);
  endtask
  task automatic t_flush;
    apb(1'b1, RB, 32'h18);
    chk("owned", 32'(serial_in_owned), 32'h1);
    apb(1'b1, RD, 32'h0f);
    wait_a(MASTER_SPI_MODE_A_RXC);
    apb(1'b1, RB, 32'h08);
    rchk("flushed", RA, 32'h60);
    chk("released", 32'(serial_in_owned), 32'h0);
    apb(1'b1, RA, 32'h40);
    apb(1'b1, RD, 32'hf0);
    apb(1'b1, RB, 32'h0);
    chk("still driven", 32'(serial_out_oe_n), 32'h0);
    wait_a(MASTER_SPI_MODE_A_TXC);
    repeat (2) @(negedge sys_clk);
    chk("let go", 32'(serial_out_oe_n), 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_modes();
    t_fmt();
    t_b2b();
    t_irq();
    t_flush();
    wrap_up();
  end
  // the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
